// ===== hdl/smrl_pkg.sv
package smrl_pkg;

    // core clock period
    localparam int CLK_PERIOD_NS = 50;

    // supply timing figures
    localparam int POR_MIN_NS    = 361;
    localparam int POR_DELAY_NS  = 700;
    localparam int UV_FILTER_NS  = 1300;

    // derived cycle counts
    localparam int POR_MIN_CYC   = (POR_MIN_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int POR_DELAY_CYC = POR_DELAY_NS / CLK_PERIOD_NS;
    localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam logic [2:0] SOFT_RST_CYC = 3'h4;

    // serial frame layout
    localparam int ADDR_W        = 9;
    localparam int DATA_W        = 16;
    localparam int CMD_WRITE_BIT = 15;
    localparam logic [5:0] CMD_LAST_BIT   = 6'h0f;
    localparam logic [5:0] FRAME_LAST_BIT = 6'h1f;
    localparam logic [5:0] FRAME_DONE     = 6'h20;

    typedef logic [ADDR_W-1:0] smrl_addr_t;
    typedef logic [DATA_W-1:0] smrl_word_t;

    // register map
    localparam smrl_addr_t REG_IRQ_CONFIG    = 9'h1c5;
    localparam smrl_addr_t REG_FAULT_FLAGS   = 9'h1d2;
    localparam smrl_addr_t REG_CHIP_IDENTITY = 9'h1d5;
    localparam smrl_addr_t REG_SOFT_RESET    = 9'h1ff;

    // field positions and reset values
    localparam int BIT_MAIN_UV = 0;
    localparam int BIT_GATE_UV = 1;
    localparam smrl_word_t FIELD_MASK       = 16'h0003;
    localparam smrl_word_t IRQ_CONFIG_RST   = 16'h0000;
    localparam smrl_word_t FAULT_FLAGS_RST  = 16'h0000;
    localparam smrl_word_t CTRL_PATTERN     = 16'h00a8;
    localparam smrl_word_t CHIP_ID_VALUE    = 16'h5a3c; // arbitrary value

endpackage

// ===== hdl/smrl_flt_if.sv
`timescale 1ns/1ps
// carrier between the core and its glitch filters
interface smrl_flt_if;
    logic clk;
    logic rst_n;
    logic raw;
    logic level;

    modport filter (
        input  clk,
        input  rst_n,
        input  raw,
        output level
    );
    modport user (
        output clk,
        output rst_n,
        output raw,
        input  level
    );
endinterface

// ===== hdl/smrl_glitch_filter.sv
`timescale 1ns/1ps
module smrl_glitch_filter #(
    parameter int SET_CYC = 1,
    parameter int CLR_CYC = 1
) (
    smrl_flt_if.filter flt
);

    localparam logic [5:0] SET_LIM = 6'(SET_CYC - 1);
    localparam logic [5:0] CLR_LIM = 6'(CLR_CYC - 1);

    logic [5:0] count;
    logic [5:0] limit;

    // limit depends on the direction of the pending change
    assign limit = flt.level ? CLR_LIM : SET_LIM;

    ////////////////////////////////////////////////////////////////////////
    // level follows raw only after a steady run of cycles
    always_ff @(posedge flt.clk or negedge flt.rst_n) begin
        if (!flt.rst_n) begin
            count     <= 6'h00;
            flt.level <= 1'b0;
        end else if (flt.raw == flt.level) begin
            count <= 6'h00;
        end else if (count >= limit) begin
            count     <= 6'h00;
            flt.level <= flt.raw;
        end else begin
            count <= count + 6'h01;
        end
    end

endmodule

// ===== hdl/smrl_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: core reset is the AND of reset_n_in, power-on, external pin and serial resets.
// R2: core reset clears the register logic and write crossing; pin synchronisers, filters, soft reset and supply switches reset only on reset_n_in.
// R3: while core reset is low the serial port ignores the host entirely.
// R4: outside reset the command word returns 0xa8; in reset it differs.
// R5: in reset every register read returns zero, identity included.
// R6: a core supply low for the minimum time plus the detection delay raises power-on reset.
// R7: the core regulator starts only after bandgap good is seen.
// R8: the core regulator stays on with 5 V alone, whatever else is absent.
// R9: 5 V overvoltage disconnects the supply until it is back to normal.
// R10: 5 V above the lower overvoltage level shuts the gate regulator.
// R11: 5 V or gate supply undervoltage turns all pre-drivers off.
// R12: a 5 V undervoltage sets its flag in the fault flag register.
// R13: an enabled 5 V undervoltage raises the interrupt request in the same cycle as its flag sets.
// R14: 5 V undervoltage is reported only after the glitch filter time.
// R15: core reset asserts at once and releases on a core clock edge.
module smrl_top
    import smrl_pkg::*;
(
    input  wire logic sys_clk_in,
    input  wire logic reset_n_in,
    input  wire logic external_reset_pin_in,
    input  wire logic core_logic_supply_low_in,
    input  wire logic bandgap_good_in,
    input  wire logic main_supply_undervoltage_in,
    input  wire logic gate_supply_undervoltage_in,
    input  wire logic main_supply_overvoltage_in,
    input  wire logic main_supply_ov_gate_in,
    input  wire logic spi_sclk_in,
    input  wire logic spi_cs_n_in,
    input  wire logic spi_mosi_in,
    output logic      spi_miso_out,
    output logic      core_reset_n_out,
    output logic      core_regulator_enable_out,
    output logic      main_supply_disconnect_out,
    output logic      gate_regulator_shutdown_out,
    output logic      predriver_disable_out,
    output logic      irq_n_out
);

    // synchroniser lanes
    localparam int PIN_W       = 7;
    localparam int PIN_SUP_LOW = 0;
    localparam int PIN_BANDGAP_GOOD   = 1;
    localparam int PIN_MAIN_UV = 2;
    localparam int PIN_GATE_UV = 3;
    localparam int PIN_OV_DISC = 4;
    localparam int PIN_OV_GATE = 5;
    localparam int PIN_CS_N    = 6;

    // pin synchronisers
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_sync;

    // reset tree
    logic             power_on_reset_n;
    logic             serial_soft_reset_n;
    logic             rst_comb_n;
    logic             rst_stage;
    logic             core_reset_n;
    logic             spi_rst_n;

    // power-on delay
    logic [5:0]       por_delay;

    // soft reset pulse
    logic [2:0]       soft_cnt;
    logic             soft_req;

    // registers and snapshots
    smrl_word_t       irq_config;
    smrl_word_t       fault_flags;
    smrl_word_t       next_flags;
    smrl_word_t       flag_set;
    smrl_word_t       flag_clr;
    smrl_word_t       snap_config;
    smrl_word_t       snap_flags;
    smrl_word_t       snap_id;
    logic             snap_alive;

    // serial side
    logic [5:0]       bit_cnt;
    logic [15:0]      rx_shift;
    smrl_word_t       cmd;
    smrl_addr_t       wr_addr;
    smrl_word_t       wr_data;
    logic             wr_tog;
    smrl_word_t       rd_word;
    smrl_word_t       tx_word;
    logic             next_miso;

    // write event crossing
    logic             wr_meta;
    logic             wr_sync;
    logic             wr_prev;
    logic             wr_seen;

    // filtered levels, gate undervoltage synchronised only
    logic             main_uv;
    logic             gate_uv;
    logic             supply_low;

    smrl_flt_if por_if ();
    smrl_flt_if uv_if ();

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, one pair of flops per lane
    assign pin_raw[PIN_SUP_LOW] = core_logic_supply_low_in;
    assign pin_raw[PIN_BANDGAP_GOOD]   = bandgap_good_in;
    assign pin_raw[PIN_MAIN_UV] = main_supply_undervoltage_in;
    assign pin_raw[PIN_GATE_UV] = gate_supply_undervoltage_in;
    assign pin_raw[PIN_OV_DISC] = main_supply_overvoltage_in;
    assign pin_raw[PIN_OV_GATE] = main_supply_ov_gate_in;
    assign pin_raw[PIN_CS_N]    = spi_cs_n_in;

    generate
        for (genvar i = 0; i < PIN_W; i++) begin : g_sync
            logic meta;
            logic sync;
            // each lane owns its flops, so no vector has two writers
            always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    meta <= 1'b0;
                    sync <= 1'b0;
                end else begin
                    meta <= pin_raw[i];
                    sync <= meta;
                end
            end
            assign pin_sync[i] = sync;
        end
    endgenerate

    assign gate_uv = pin_sync[PIN_GATE_UV];

    ////////////////////////////////////////////////////////////////////////
    // glitch filters
    assign por_if.clk   = sys_clk_in;
    assign por_if.rst_n = reset_n_in;
    assign por_if.raw   = pin_sync[PIN_SUP_LOW];
    assign supply_low   = por_if.level;

    // low must last the minimum time, recovery is immediate
    smrl_glitch_filter #(
        .SET_CYC (POR_MIN_CYC),
        .CLR_CYC (1)
    ) u_por_filter (
        .flt (por_if.filter)
    );

    assign uv_if.clk   = sys_clk_in;
    assign uv_if.rst_n = reset_n_in;
    assign uv_if.raw   = pin_sync[PIN_MAIN_UV];
    assign main_uv     = uv_if.level;

    // undervoltage shorter than the filter time is dropped
    smrl_glitch_filter #(
        .SET_CYC (UV_FILTER_CYC),
        .CLR_CYC (UV_FILTER_CYC)
    ) u_uv_filter (
        .flt (uv_if.filter)                                      // R14
    );

    ////////////////////////////////////////////////////////////////////////
    // power-on reset, asserted after the detection delay
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            por_delay        <= 6'h00;
            power_on_reset_n <= 1'b0;
        end else if (!supply_low) begin
            por_delay        <= 6'h00;
            power_on_reset_n <= 1'b1;                            // R6
        end else if (por_delay == 6'(POR_DELAY_CYC - 1)) begin
            power_on_reset_n <= 1'b0;                            // R6
        end else begin
            por_delay <= por_delay + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // soft reset pulse; survives the core reset it causes
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            soft_cnt            <= 3'h0;
            serial_soft_reset_n <= 1'b1;
        end else if (soft_req) begin
            soft_cnt            <= SOFT_RST_CYC;
            serial_soft_reset_n <= 1'b0;
        end else if (soft_cnt != 3'h0) begin
            soft_cnt <= soft_cnt - 3'h1;
        end else begin
            serial_soft_reset_n <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // combined core reset, async assert, sync release
    assign rst_comb_n = reset_n_in & power_on_reset_n            // R1
                      & external_reset_pin_in & serial_soft_reset_n;

    always_ff @(posedge sys_clk_in or negedge rst_comb_n) begin
        if (!rst_comb_n) begin
            rst_stage    <= 1'b0;
            core_reset_n <= 1'b0;                                // R15
        end else begin
            rst_stage    <= 1'b1;
            core_reset_n <= rst_stage;                           // R15
        end
    end

    assign core_reset_n_out = core_reset_n;

    ////////////////////////////////////////////////////////////////////////
    // supply switches driven by the monitors
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_regulator_enable_out   <= 1'b0;
            main_supply_disconnect_out  <= 1'b0;
            gate_regulator_shutdown_out <= 1'b1;
            predriver_disable_out       <= 1'b1;
        end else begin
            // only bandgap good gates the core regulator
            core_regulator_enable_out   <= pin_sync[PIN_BANDGAP_GOOD];  // R7 R8
            main_supply_disconnect_out  <= pin_sync[PIN_OV_DISC]; // R9
            gate_regulator_shutdown_out <= pin_sync[PIN_OV_GATE] // R10
                                         | ~core_reset_n;
            predriver_disable_out       <= main_uv | gate_uv     // R11
                                         | ~core_reset_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // write event crossing from the serial clock
    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            wr_meta <= 1'b0;
            wr_sync <= 1'b0;
            wr_prev <= 1'b0;
        end else begin
            wr_meta <= wr_tog;
            wr_sync <= wr_meta;
            wr_prev <= wr_sync;
        end
    end

    assign wr_seen = wr_sync ^ wr_prev;

    ////////////////////////////////////////////////////////////////////////
    // interrupt configuration register
    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            irq_config <= IRQ_CONFIG_RST;                        // R2
        end else if (wr_seen && wr_addr == REG_IRQ_CONFIG) begin
            irq_config <= wr_data & FIELD_MASK;
        end
    end

    // soft reset request on a write to its address
    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            soft_req <= 1'b0;
        end else begin
            soft_req <= wr_seen && (wr_addr == REG_SOFT_RESET);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault flags, write one to clear, set wins
    always_comb begin
        flag_set              = '0;
        flag_set[BIT_MAIN_UV] = main_uv;                         // R12
        flag_set[BIT_GATE_UV] = gate_uv;
        flag_clr              = '0;
        if (wr_seen && wr_addr == REG_FAULT_FLAGS) begin
            flag_clr = wr_data & FIELD_MASK;
        end
        next_flags = (fault_flags & ~flag_clr) | flag_set;
    end

    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            fault_flags <= FAULT_FLAGS_RST;
        end else begin
            fault_flags <= next_flags;
        end
    end

    // interrupt request from the next flag value, no extra cycle
    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            irq_n_out <= 1'b1;
        end else begin
            irq_n_out <= ~|(next_flags & irq_config);            // R13
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read snapshot, frozen while a frame is open
    always_ff @(posedge sys_clk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            snap_config <= '0;                                   // R5
            snap_flags  <= '0;                                   // R5
            snap_id     <= '0;                                   // R5
            snap_alive  <= 1'b0;                                 // R4
        end else if (pin_sync[PIN_CS_N]) begin
            snap_config <= irq_config;
            snap_flags  <= fault_flags;
            snap_id     <= CHIP_ID_VALUE;
            snap_alive  <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial port held in reset when deselected or in core reset
    assign spi_rst_n = core_reset_n & ~spi_cs_n_in;              // R3

    // receive shift and bit count on rising edges
    always_ff @(posedge spi_sclk_in or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            bit_cnt  <= 6'h00;
            rx_shift <= 16'h0000;
        end else begin
            rx_shift <= {rx_shift[14:0], spi_mosi_in};
            if (bit_cnt != FRAME_DONE) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
        end
    end

    // command word capture
    always_ff @(posedge spi_sclk_in or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            cmd <= '0;
        end else if (bit_cnt == CMD_LAST_BIT) begin
            cmd <= {rx_shift[14:0], spi_mosi_in};
        end
    end

    // write hold registers, kept across deselect
    always_ff @(posedge spi_sclk_in or negedge core_reset_n) begin
        if (!core_reset_n) begin
            wr_addr <= '0;
            wr_data <= '0;
            wr_tog  <= 1'b0;
        end else if (bit_cnt == FRAME_LAST_BIT && cmd[CMD_WRITE_BIT]) begin
            wr_addr <= cmd[ADDR_W-1:0];
            wr_data <= {rx_shift[14:0], spi_mosi_in};
            wr_tog  <= ~wr_tog;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data selection from the frozen snapshot
    always_comb begin
        rd_word = '0;
        if (!cmd[CMD_WRITE_BIT]) begin
            case (cmd[ADDR_W-1:0])
                REG_IRQ_CONFIG:    rd_word = snap_config;
                REG_FAULT_FLAGS:   rd_word = snap_flags;
                REG_CHIP_IDENTITY: rd_word = snap_id;
                default:           rd_word = '0;
            endcase
        end
    end

    // pattern during command word, data during data word
    always_comb begin
        if (bit_cnt[5:4] == 2'b00) begin
            tx_word = snap_alive ? CTRL_PATTERN : '0;            // R4
        end else begin
            tx_word = rd_word;                                   // R5
        end
        next_miso = 1'b0;
        if (bit_cnt != FRAME_DONE) begin
            next_miso = tx_word[~bit_cnt[3:0]];
        end
    end

    // transmit on falling edges
    always_ff @(negedge spi_sclk_in or negedge spi_rst_n) begin
        if (!spi_rst_n) begin
            spi_miso_out <= 1'b0;
        end else begin
            spi_miso_out <= next_miso;
        end
    end

endmodule

// ===== test/smrl_spi_host.sv
`timescale 1ns/1ps
// host side of the serial link, clock runs only inside frames
module smrl_spi_host (
    input  wire logic miso_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    ////////////////////////////////////////////////////////////////////
    // idle: deselected, clock still low, data line never holds a value
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    always #48 if (cs_n_out) mosi_out = ~mosi_out;

    // one 32-bit frame, mode 0, msb first, 48 ns link period
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        #7 cs_n_out = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_out = tx[i];
            #24 sclk_out = 1'b1;
            rx[i] = miso_in;
            #24 sclk_out = 1'b0;
        end
        #24 cs_n_out = 1'b1;
    endtask
endmodule

// ===== test/smrl_top_asserts.sv
`timescale 1ns/1ps
// supply and reset relations seen at the monitor top ports
module smrl_top_asserts (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic external_reset_pin_in,
    input wire logic core_logic_supply_low_in,
    input wire logic bandgap_good_in,
    input wire logic main_supply_undervoltage_in,
    input wire logic gate_supply_undervoltage_in,
    input wire logic main_supply_overvoltage_in,
    input wire logic main_supply_ov_gate_in,
    input wire logic spi_miso_out,
    input wire logic core_reset_n_out,
    input wire logic core_regulator_enable_out,
    input wire logic main_supply_disconnect_out,
    input wire logic gate_regulator_shutdown_out,
    input wire logic predriver_disable_out
);
    logic [5:0] uv_cnt;
    logic [4:0] low_cnt;

    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!reset_n_in);

    ////////////////////////////////////////////////////////////////////
    // saturating run lengths of undervoltage and low core supply
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            uv_cnt <= 6'h00;
        end else begin
            uv_cnt <= main_supply_undervoltage_in ?
                      uv_cnt + {5'h00, uv_cnt != 6'h3f} : 6'h00;
        end
    end
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            low_cnt <= 5'h00;
        end else begin
            low_cnt <= core_logic_supply_low_in ?
                       low_cnt + {4'h0, low_cnt != 5'h1f} : 5'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////
    pin_reset_a: assert property (
        !external_reset_pin_in |-> !core_reset_n_out)
        else $error("core reset high while pin low");
    sync_release_a: assert property (
        $rose(core_reset_n_out) |-> $past(external_reset_pin_in, 2))
        else $error("core reset left without synchroniser");
    link_quiet_a: assert property (
        !core_reset_n_out |-> !spi_miso_out)
        else $error("serial output active in reset");
    por_assert_a: assert property (
        low_cnt == 5'h1e |-> !core_reset_n_out)
        else $error("long supply dip gave no reset");
    bg_start_a: assert property (
        $rose(core_regulator_enable_out) |-> $past(bandgap_good_in, 3))
        else $error("regulator started without bandgap");
    ov_disc_a: assert property (
        $rose(main_supply_overvoltage_in) |-> ##3 main_supply_disconnect_out)
        else $error("overvoltage disconnect late");
    ov_gate_a: assert property (
        $rose(main_supply_ov_gate_in) |-> ##3 gate_regulator_shutdown_out)
        else $error("gate regulator not shut");
    gate_uv_a: assert property (
        $rose(gate_supply_undervoltage_in) |-> ##3 predriver_disable_out)
        else $error("gate undervoltage left drivers on");
    uv_filter_a: assert property (
        $rose(predriver_disable_out) && core_reset_n_out &&
        !$past(gate_supply_undervoltage_in, 3) |->
        uv_cnt >= 6'h1a && uv_cnt <= 6'h21)
        else $error("undervoltage filter time wrong");
    uv_hold_a: assert property (
        uv_cnt == 6'h24 |-> predriver_disable_out)
        else $error("lasting undervoltage left drivers on");
endmodule

bind smrl_top smrl_top_asserts smrl_top_asserts_inst (
    .sys_clk_in, .reset_n_in, .external_reset_pin_in,
    .core_logic_supply_low_in, .bandgap_good_in,
    .main_supply_undervoltage_in, .gate_supply_undervoltage_in,
    .main_supply_overvoltage_in, .main_supply_ov_gate_in, .spi_miso_out,
    .core_reset_n_out, .core_regulator_enable_out,
    .main_supply_disconnect_out, .gate_regulator_shutdown_out,
    .predriver_disable_out
);

// ===== test/supply_monitor_reset_logic_test.sv
`timescale 1ns/1ps
module supply_monitor_reset_logic_test;
    import smrl_pkg::*;

    logic        clk, rst_n, pin_n, sup_low, bg, uv5, uvg, ov, ovg;
    logic        sclk, cs_n, mosi, miso, core_n, reg_en, disc, gshut;
    logic        pdis, irq_n, dipped;
    logic [31:0] rx;
    int          fails;
    int          comparisons;

    smrl_top smrl_top_inst (
        .sys_clk_in(clk), .reset_n_in(rst_n),
        .external_reset_pin_in(pin_n), .core_logic_supply_low_in(sup_low),
        .bandgap_good_in(bg), .main_supply_undervoltage_in(uv5),
        .gate_supply_undervoltage_in(uvg),
        .main_supply_overvoltage_in(ov), .main_supply_ov_gate_in(ovg),
        .spi_sclk_in(sclk), .spi_cs_n_in(cs_n), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .core_reset_n_out(core_n),
        .core_regulator_enable_out(reg_en),
        .main_supply_disconnect_out(disc),
        .gate_regulator_shutdown_out(gshut),
        .predriver_disable_out(pdis), .irq_n_out(irq_n)
    );
    smrl_spi_host smrl_spi_host_inst (
        .miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi)
    );

    // core clock and a watch for any dip of the core reset
    initial clk = 1'b0;
    always #25 clk = ~clk;
    always @(negedge core_n) dipped = 1'b1;

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // supply and reset inputs change only at falling edges
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // bounded wait for the core to leave reset, then a select gap
    task automatic wait_core();
        for (int i = 0; i < 200 && core_n !== 1'b1; i++) cyc(1);
        if (core_n !== 1'b1) begin
            fails++;
            $display("ERROR %0t: core stuck in reset", $time);
            conclude();
        end
        cyc(6);
    endtask

    task automatic frame(input logic [15:0] cmd, input logic [15:0] dat);
        smrl_spi_host_inst.xfer({cmd, dat}, rx);
        cyc(6);
    endtask

    task automatic rd(input smrl_addr_t a, input smrl_word_t exp);
        frame({7'h00, a}, 16'h0000);
        check(rx, {CTRL_PATTERN, exp});
    endtask

    task automatic wr(input smrl_addr_t a, input smrl_word_t d);
        frame({7'h40, a}, d);
    endtask

    ////////////////////////////////////////////////////////////////////
    // reset pin: core held, link silent, registers cleared
    task automatic t_pin();
        wr(REG_IRQ_CONFIG, 16'h0003);
        rd(REG_IRQ_CONFIG, 16'h0003);
        pin_n = 1'b0;
        cyc(1);
        check(32'(core_n), 32'h0);
        check(32'({gshut, pdis}), 32'h3);
        frame({7'h00, REG_CHIP_IDENTITY}, 16'h0000);
        check(rx, 32'h0);
        pin_n = 1'b1;
        wait_core();
        rd(REG_IRQ_CONFIG, IRQ_CONFIG_RST);
        dipped = 1'b0;
        wr(REG_IRQ_CONFIG, 16'h0001);
        wr(REG_SOFT_RESET, 16'h0000);
        check(32'(dipped), 32'h1);
        wait_core();
        rd(REG_IRQ_CONFIG, IRQ_CONFIG_RST);
        $display("test reset sources done");
    endtask

    // short core supply dip is ignored, a long one resets
    task automatic t_por();
        dipped = 1'b0;
        sup_low = 1'b1;
        cyc(5);
        sup_low = 1'b0;
        cyc(40);
        check(32'(dipped), 32'h0);
        sup_low = 1'b1;
        cyc(32);
        check(32'(core_n), 32'h0);
        sup_low = 1'b0;
        wait_core();
        rd(REG_CHIP_IDENTITY, CHIP_ID_VALUE);
        $display("test power-on reset done");
    endtask

    // overvoltage levels, bandgap start and 5 V-only operation
    task automatic t_supply();
        ovg = 1'b1;
        cyc(3);
        check(32'({disc, gshut}), 32'h1);
        ov = 1'b1;
        cyc(3);
        check(32'({disc, gshut}), 32'h3);
        {ov, ovg} = 2'h0;
        cyc(3);
        check(32'({disc, gshut}), 32'h0);
        bg = 1'b0;
        cyc(4);
        check(32'(reg_en), 32'h0);
        {bg, uvg} = 2'h3;
        cyc(4);
        check(32'({reg_en, pdis}), 32'h3);
        rd(REG_CHIP_IDENTITY, CHIP_ID_VALUE);
        uvg = 1'b0;
        wr(REG_FAULT_FLAGS, 16'h0003);
        $display("test supplies done");
    endtask

    // undervoltage: glitch ignored, flag set, interrupt once enabled
    task automatic t_uv();
        uv5 = 1'b1;
        cyc(12);
        uv5 = 1'b0;
        cyc(30);
        check(32'({pdis, irq_n}), 32'h1);
        rd(REG_FAULT_FLAGS, 16'h0000);
        uv5 = 1'b1;
        cyc(40);
        check(32'({pdis, irq_n}), 32'h3);
        rd(REG_FAULT_FLAGS, 16'h0001);
        wr(REG_IRQ_CONFIG, 16'h0001);
        check(32'(irq_n), 32'h0);
        uv5 = 1'b0;
        cyc(30);
        wr(REG_FAULT_FLAGS, 16'h0001);
        check(32'({pdis, irq_n}), 32'h1);
        rd(REG_FAULT_FLAGS, 16'h0000);
        $display("test undervoltage done");
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        fails = 0;
        comparisons = 0;
        dipped = 1'b0;
        {rst_n, pin_n, sup_low, bg} = 4'h5;
        {uv5, uvg, ov, ovg} = 4'h0;
        cyc(12);
        rst_n = 1'b1;
        wait_core();
        rd(REG_CHIP_IDENTITY, CHIP_ID_VALUE);
        rd(REG_FAULT_FLAGS, FAULT_FLAGS_RST);
        rd(9'h000, 16'h0000);
        check(32'({reg_en, disc, gshut, pdis, irq_n}), 32'h11);
        t_pin();
        t_por();
        t_supply();
        t_uv();
        conclude();
    end
endmodule
